// file: logic/irab_defs.vh
/*
 Constants for the indirect register access bridge: register offsets,
 field positions, reset values and target codes.
 Assumes it is included by the bridge module only.
*/
// Overview of operation
// - The 3-bit analog target field routes accesses: 000 off, 001-011 channels 0-2, 100 shared, 101 link transmitter, 110 all three channels.
// - With analog autostep on, the analog offset steps by one after each completed indirect read or write.
// - With the read strobe enable set, writing the analog offset sends a read strobe to the selected analog block.
// - With read strobe enable and autostep both on, each host read of the analog value is followed by another read strobe that prefetches the next location.
// - The analog offset register holds the 8-bit offset within the chosen analog target.
// - A host write of the analog value writes that byte to the selected target at the current offset.
// - A host read of the analog value returns the selected target register at the current offset.
// - The 2-bit peripheral target field picks controller, identification memory, configuration data or die identifier; the last two are read-only.
// - With peripheral autostep on, the address steps by 4 for the controller and by 1 otherwise after each completed read or write.
// - Writing 1 to the peripheral read start launches a read, loads the result into the value bytes and clears the bit on completion.
// - The peripheral interface acts only while its enable bit is 1, on the target given by the target field.
// - The peripheral address is a low and a high byte register, readable, writable and cleared at reset.
// - Peripheral data is four byte registers forming a 32-bit word, byte 0 least significant.
`ifndef IRAB_DEFS_VH
`define IRAB_DEFS_VH
`define IRAB_ADDR_ANA_CTL 8'h40
`define IRAB_ADDR_ANA_OFS 8'h41
`define IRAB_ADDR_ANA_VAL 8'h42
`define IRAB_ADDR_PB_CTL 8'h48
`define IRAB_ADDR_PB_ADR0 8'h49
`define IRAB_ADDR_PB_ADR1 8'h4a
`define IRAB_ADDR_PB_DAT0 8'h4b
`define IRAB_ADDR_PB_DAT1 8'h4c
`define IRAB_ADDR_PB_DAT2 8'h4d
`define IRAB_ADDR_PB_DAT3 8'h4e
`define IRAB_RST_BYTE 8'h00
`define IRAB_ANA_SEL_MSB 4
`define IRAB_ANA_SEL_LSB 2
`define IRAB_ANA_STEP_BIT 1
`define IRAB_ANA_RDEN_BIT 0
`define IRAB_PB_SEL_MSB 4
`define IRAB_PB_SEL_LSB 3
`define IRAB_PB_STEP_BIT 2
`define IRAB_PB_READ_BIT 1
`define IRAB_PB_EN_BIT 0
`define IRAB_ANA_SEL_OFF 3'h0
`define IRAB_ANA_SEL_CH0 3'h1
`define IRAB_ANA_SEL_CH1 3'h2
`define IRAB_ANA_SEL_CH2 3'h3
`define IRAB_ANA_SEL_SHR 3'h4
`define IRAB_ANA_SEL_LTX 3'h5
`define IRAB_ANA_SEL_ALL 3'h6
`define IRAB_PB_SEL_CTRL 2'h0
`define IRAB_PB_SEL_IDMEM 2'h1
`define IRAB_PB_SEL_CFG 2'h2
`define IRAB_PB_SEL_DIE 2'h3
`define IRAB_PB_STEP_CTRL 16'h0004
`define IRAB_PB_STEP_OTHER 16'h0001
`endif

// file: logic/irab_bridge.v
/*
 Indirect register access bridge: host byte registers reach five analog
 register blocks and a four-target APB space.
 Assumes host strobes are one cycle, never together, and APB slaves
 answer with pready; analog blocks return read data combinationally.
*/
`timescale 1ns/1ps
`include "irab_defs.vh"
module irab_bridge (
   input wire clk_sys_i,
   input wire rstn_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [7:0] reg_rdata_o,
   output reg [5:0] ana_sel_o,
   output reg [7:0] ana_offset_o,
   output reg [7:0] ana_wdata_o,
   output reg ana_wr_o,
   output reg ana_rd_o,
   input wire [47:0] ana_rdata_i,
   output reg [1:0] apb_target_o,
   output reg [15:0] apb_paddr_o,
   output reg apb_psel_o,
   output reg apb_penable_o,
   output reg apb_pwrite_o,
   output reg [31:0] apb_pwdata_o,
   input wire [31:0] apb_prdata_i,
   input wire apb_pready_i
);
   localparam ST_IDLE = 2'h0;
   localparam ST_SETUP = 2'h1;
   localparam ST_ACCESS = 2'h2;
   reg [7:0] ana_ctl_q;
   reg [7:0] ana_ofs_q;
   reg [7:0] ana_val_q;
   reg [4:0] pb_ctl_q;
   reg [15:0] pb_adr_q;
   reg [31:0] pb_dat_q;
   reg [1:0] st_q;
   reg ana_rd_step_q;
   reg [5:0] sel_vec;
   reg [7:0] ana_rsel;
   reg [7:0] rd_mux;
   integer k;
   wire [2:0] ana_tgt = ana_ctl_q[`IRAB_ANA_SEL_MSB:`IRAB_ANA_SEL_LSB];
   wire ana_step = ana_ctl_q[`IRAB_ANA_STEP_BIT];
   wire ana_rden = ana_ctl_q[`IRAB_ANA_RDEN_BIT];
   wire [1:0] pb_tgt = pb_ctl_q[`IRAB_PB_SEL_MSB:`IRAB_PB_SEL_LSB];
   wire pb_en = pb_ctl_q[`IRAB_PB_EN_BIT];
   wire pb_ro = (pb_tgt == `IRAB_PB_SEL_CFG) || (pb_tgt == `IRAB_PB_SEL_DIE);
   wire wr_ana_ofs = reg_wr_i && (reg_addr_i == `IRAB_ADDR_ANA_OFS);
   wire wr_ana_val = reg_wr_i && (reg_addr_i == `IRAB_ADDR_ANA_VAL);
   wire rd_ana_val = reg_rd_i && (reg_addr_i == `IRAB_ADDR_ANA_VAL);
   wire wr_pb_ctl = reg_wr_i && (reg_addr_i == `IRAB_ADDR_PB_CTL);
   wire wr_pb_d3 = reg_wr_i && (reg_addr_i == `IRAB_ADDR_PB_DAT3);
   wire wr_ana_ctl = reg_wr_i && (reg_addr_i == `IRAB_ADDR_ANA_CTL);
   wire [2:0] ana_tgt_d = wr_ana_ctl ? reg_wdata_i[`IRAB_ANA_SEL_MSB:`IRAB_ANA_SEL_LSB] :
                          ana_tgt;
   wire ana_live = (ana_tgt != `IRAB_ANA_SEL_OFF) && (ana_tgt <= `IRAB_ANA_SEL_ALL);
   wire pb_done = (st_q == ST_ACCESS) && apb_pready_i;
   wire [15:0] pb_step = (pb_tgt == `IRAB_PB_SEL_CTRL) ? `IRAB_PB_STEP_CTRL :
                         `IRAB_PB_STEP_OTHER;

   // Enables, one-hot except broadcast (bits 0-2): channels 0-2, shared, link transmitter.
   // Decoded from the value the control register is about to take, so the enables
   // already show a new target when a read of the analog value follows at once.
   always @* begin
      sel_vec = 6'h00;
      case (ana_tgt_d)
         `IRAB_ANA_SEL_CH0: sel_vec = 6'h01;
         `IRAB_ANA_SEL_CH1: sel_vec = 6'h02;
         `IRAB_ANA_SEL_CH2: sel_vec = 6'h04;
         `IRAB_ANA_SEL_SHR: sel_vec = 6'h08;
         `IRAB_ANA_SEL_LTX: sel_vec = 6'h10;
         `IRAB_ANA_SEL_ALL: sel_vec = 6'h07;
         default: sel_vec = 6'h00;
      endcase
   end

   // In broadcast mode the reply of channel 0 is the one returned.
   always @* begin
      ana_rsel = 8'h00;
      for (k = 0; k < 6; k = k + 1) begin
         if (sel_vec[k] && (ana_rsel == 8'h00) && !(k > 0 && sel_vec[0])) begin
            ana_rsel = ana_rdata_i[k*8 +: 8];
         end
      end
   end

   always @* begin
      case (reg_addr_i)
         `IRAB_ADDR_ANA_CTL: rd_mux = ana_ctl_q;
         `IRAB_ADDR_ANA_OFS: rd_mux = ana_ofs_q;
         `IRAB_ADDR_ANA_VAL: rd_mux = ana_live ? ana_rsel : ana_val_q;
         `IRAB_ADDR_PB_CTL: rd_mux = {3'h0, pb_ctl_q};
         `IRAB_ADDR_PB_ADR0: rd_mux = pb_adr_q[7:0];
         `IRAB_ADDR_PB_ADR1: rd_mux = pb_adr_q[15:8];
         `IRAB_ADDR_PB_DAT0: rd_mux = pb_dat_q[7:0];
         `IRAB_ADDR_PB_DAT1: rd_mux = pb_dat_q[15:8];
         `IRAB_ADDR_PB_DAT2: rd_mux = pb_dat_q[23:16];
         `IRAB_ADDR_PB_DAT3: rd_mux = pb_dat_q[31:24];
         default: rd_mux = 8'h00;
      endcase
   end

   // Host-facing register file and analog strobes.
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ana_ctl_q <= `IRAB_RST_BYTE;
         ana_ofs_q <= `IRAB_RST_BYTE;
         ana_val_q <= `IRAB_RST_BYTE;
         reg_rdata_o <= 8'h00;
         ana_sel_o <= 6'h00;
         ana_offset_o <= 8'h00;
         ana_wdata_o <= 8'h00;
         ana_wr_o <= 1'b0;
         ana_rd_o <= 1'b0;
         ana_rd_step_q <= 1'b0;
      end else begin
         reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
         ana_wr_o <= 1'b0;
         ana_rd_o <= 1'b0;
         ana_rd_step_q <= 1'b0;
         ana_sel_o <= sel_vec;
         ana_offset_o <= ana_ofs_q;
         if (reg_wr_i && reg_addr_i == `IRAB_ADDR_ANA_CTL) begin
            ana_ctl_q <= reg_wdata_i;
         end
         if (wr_ana_ofs) begin
            ana_ofs_q <= reg_wdata_i;
            ana_offset_o <= reg_wdata_i;
            ana_rd_o <= ana_rden && ana_live;
         end
         if (wr_ana_val) begin
            ana_val_q <= reg_wdata_i;
            ana_wdata_o <= reg_wdata_i;
            ana_wr_o <= ana_live;
            if (ana_step) begin
               ana_ofs_q <= ana_ofs_q + 8'h01;
            end
         end
         if (rd_ana_val && ana_step) begin
            ana_ofs_q <= ana_ofs_q + 8'h01;
            ana_rd_step_q <= ana_rden && ana_live;
         end
         // Prefetch strobe goes out once the stepped offset is on the port.
         if (ana_rd_step_q) begin
            ana_rd_o <= 1'b1;
         end
      end
   end

   // Peripheral bus side: control, address, data and the APB sequencer.
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pb_ctl_q <= 5'h00;
         pb_adr_q <= 16'h0000;
         pb_dat_q <= 32'h0000_0000;
         st_q <= ST_IDLE;
         apb_target_o <= 2'h0;
         apb_paddr_o <= 16'h0000;
         apb_psel_o <= 1'b0;
         apb_penable_o <= 1'b0;
         apb_pwrite_o <= 1'b0;
         apb_pwdata_o <= 32'h0000_0000;
      end else begin
         if (wr_pb_ctl) begin
            pb_ctl_q <= reg_wdata_i[4:0];
         end
         if (reg_wr_i && reg_addr_i == `IRAB_ADDR_PB_ADR0) begin
            pb_adr_q[7:0] <= reg_wdata_i;
         end
         if (reg_wr_i && reg_addr_i == `IRAB_ADDR_PB_ADR1) begin
            pb_adr_q[15:8] <= reg_wdata_i;
         end
         if (reg_wr_i && reg_addr_i == `IRAB_ADDR_PB_DAT0) begin
            pb_dat_q[7:0] <= reg_wdata_i;
         end
         if (reg_wr_i && reg_addr_i == `IRAB_ADDR_PB_DAT1) begin
            pb_dat_q[15:8] <= reg_wdata_i;
         end
         if (reg_wr_i && reg_addr_i == `IRAB_ADDR_PB_DAT2) begin
            pb_dat_q[23:16] <= reg_wdata_i;
         end
         if (wr_pb_d3) begin
            pb_dat_q[31:24] <= reg_wdata_i;
         end
         case (st_q)
            ST_IDLE: begin
               // Host writes to address/data land first, so a start
               // uses the freshly programmed values one cycle later.
               if (pb_en && pb_ctl_q[`IRAB_PB_READ_BIT] && !wr_pb_ctl) begin
                  st_q <= ST_SETUP;
                  apb_target_o <= pb_tgt;
                  apb_paddr_o <= pb_adr_q;
                  apb_psel_o <= 1'b1;
                  apb_pwrite_o <= 1'b0;
               end else if (pb_en && wr_pb_d3 && !pb_ro) begin
                  st_q <= ST_SETUP;
                  apb_target_o <= pb_tgt;
                  apb_paddr_o <= pb_adr_q;
                  apb_psel_o <= 1'b1;
                  apb_pwrite_o <= 1'b1;
                  apb_pwdata_o <= {reg_wdata_i, pb_dat_q[23:0]};
               end
            end
            ST_SETUP: begin
               st_q <= ST_ACCESS;
               apb_penable_o <= 1'b1;
            end
            ST_ACCESS: begin
               if (apb_pready_i) begin
                  st_q <= ST_IDLE;
                  apb_psel_o <= 1'b0;
                  apb_penable_o <= 1'b0;
                  apb_pwrite_o <= 1'b0;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
         if (pb_done) begin
            if (!apb_pwrite_o) begin
               pb_dat_q <= apb_prdata_i;
               // Completion clears the start bit unless the host sets it again now.
               if (!wr_pb_ctl) begin
                  pb_ctl_q[`IRAB_PB_READ_BIT] <= 1'b0;
               end
            end
            if (pb_ctl_q[`IRAB_PB_STEP_BIT]) begin
               pb_adr_q <= pb_adr_q + pb_step;
            end
         end
         // Disabling the interface drops any pending read start.
         if (!pb_en && !wr_pb_ctl && st_q == ST_IDLE) begin
            pb_ctl_q[`IRAB_PB_READ_BIT] <= 1'b0;
         end
      end
   end
endmodule // irab_bridge

// file: tb/irab_bridge_properties.sv
/* Checker for the bridge ports.
 Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ps
module irab_bridge_properties (
   input wire clk_sys_i,
   input wire rstn_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_rdata_o,
   input wire [5:0] ana_sel_o,
   input wire [7:0] ana_offset_o,
   input wire [7:0] ana_wdata_o,
   input wire ana_wr_o,
   input wire ana_rd_o,
   input wire [47:0] ana_rdata_i,
   input wire [1:0] apb_target_o,
   input wire [15:0] apb_paddr_o,
   input wire apb_psel_o,
   input wire apb_penable_o,
   input wire apb_pwrite_o,
   input wire [31:0] apb_pwdata_o,
   input wire [31:0] apb_prdata_i,
   input wire apb_pready_i
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   wire val_wr = reg_wr_i && reg_addr_i == 8'h42;
   wire val_rd = reg_rd_i && reg_addr_i == 8'h42;
   wire ofs_wr = reg_wr_i && reg_addr_i == 8'h41;
   sequence apb_setup; apb_psel_o && !apb_penable_o; endsequence
   sequence apb_access; apb_psel_o && apb_penable_o; endsequence
   chk_sel_shape: assert property ($onehot0(ana_sel_o) || ana_sel_o == 6'h07)
      else $error("bad analog enables");
   chk_ana_write: assert property (val_wr |=>
      ana_wr_o == (ana_sel_o != 6'h00) && ana_wdata_o == $past(reg_wdata_i))
      else $error("analog write lost");
   chk_offset_load: assert property (ofs_wr |=> ana_offset_o == $past(reg_wdata_i))
      else $error("offset not loaded");
   chk_strobe_cause: assert property (ana_rd_o |->
      $past(ofs_wr) || $past(val_rd, 2))
      else $error("stray read strobe");
   chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data outside slot");
   chk_apb_phase: assert property ($rose(apb_psel_o) |-> apb_setup ##1 apb_access)
      else $error("apb phase order");
   chk_apb_hold: assert property (apb_penable_o && !apb_pready_i |=>
      apb_penable_o && $stable(apb_paddr_o))
      else $error("apb access dropped");
   chk_apb_end: assert property (apb_penable_o && apb_pready_i |=> !apb_psel_o)
      else $error("apb not closed");
   chk_apb_rdonly: assert property (apb_psel_o && apb_pwrite_o |->
      apb_target_o < 2'h2)
      else $error("write to read-only space");
endmodule // irab_bridge_properties
bind irab_bridge irab_bridge_properties irab_bridge_properties_i (.*);

// file: tb/irab_far_side.sv
/* Far-side model: six analog blocks and a four-target APB slave.
 Assumes setup precedes access on APB. */
`timescale 1ns/1ps
module irab_far_side (
   input wire clk_sys_i,
   input wire [5:0] sel_i,
   input wire [7:0] ofs_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output wire [47:0] rdata_o,
   input wire [1:0] tgt_i,
   input wire [15:0] paddr_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   input wire [3:0] wait_i
);
   reg [7:0] amem [0:5][0:255];
   reg [31:0] pmem [0:3][0:255];
   integer prefetch_count = 0, k, j, w = 0;
   genvar g;
   initial begin
      prdata_o = 32'h0;
      pready_o = 1'b0;
      for (k = 0; k < 1024; k++)
         pmem[k / 256][k % 256] = {k[15:0], 16'hc3a5};
   end
   // Unselected blocks show a moving value, so a stale byte never passes for data.
   for (g = 0; g < 6; g = g + 1) begin : blk
      assign rdata_o[8*g +: 8] = sel_i[g] ? amem[g][ofs_i] : ~ofs_i;
   end
   always @(posedge clk_sys_i) begin
      for (j = 0; j < 6; j++)
         if (wr_i && sel_i[j])
            amem[j][ofs_i] <= wdata_i;
      if (rd_i)
         prefetch_count++;
      pready_o <= 1'b0;
      prdata_o <= ~prdata_o;
      if (psel_i && penable_i && !pready_o) begin
         w <= w + 1;
         if (w == wait_i) begin
            w <= 0;
            pready_o <= 1'b1;
            prdata_o <= pmem[tgt_i][paddr_i[7:0]];
            if (pwrite_i)
               pmem[tgt_i][paddr_i[7:0]] <= pwdata_i;
         end
      end
   end
endmodule // irab_far_side

// file: tb/tb_irab_bridge.sv
/* Self-checking bench for the bridge.
 Assumes the design, checker and far-side model are compiled first. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fail_count++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_irab_bridge;
   reg clk_sys_i = 1'b0, rstn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   reg [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, d, o, v;
   reg [3:0] wait_q = 4'h0;
   reg [31:0] rnd = 32'hb7ff6d89, wd;
   wire [7:0] reg_rdata_o, ana_offset_o, ana_wdata_o;
   wire [5:0] ana_sel_o;
   wire ana_wr_o, ana_rd_o, apb_psel_o, apb_penable_o, apb_pwrite_o, apb_pready_i;
   wire [47:0] ana_rdata_i;
   wire [1:0] apb_target_o;
   wire [15:0] apb_paddr_o;
   wire [31:0] apb_pwdata_o, apb_prdata_i;
   integer fail_count = 0, n_compared = 0, t, i, pc;
   always #12.5 clk_sys_i = ~clk_sys_i;
   irab_bridge irab_bridge_i (.*);
   irab_far_side irab_far_side_i (.clk_sys_i(clk_sys_i), .sel_i(ana_sel_o), .ofs_i(ana_offset_o),
      .wdata_i(ana_wdata_o), .wr_i(ana_wr_o), .rd_i(ana_rd_o), .rdata_o(ana_rdata_i),
      .tgt_i(apb_target_o), .paddr_i(apb_paddr_o), .psel_i(apb_psel_o),
      .penable_i(apb_penable_o), .pwrite_i(apb_pwrite_o), .pwdata_i(apb_pwdata_o),
      .prdata_o(apb_prdata_i), .pready_o(apb_pready_i), .wait_i(wait_q));
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task bus(input w, input [7:0] a, input [7:0] x);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= x;
      reg_wr_i <= w;
      reg_rd_i <= !w;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
      #1 v = reg_rdata_o;
   endtask
   task summarize;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      #500000 fail_count++;
      summarize;
   end
   task check_cleared;
      for (i = 8'h40; i < 8'h50; i++) begin
         bus(0, i[7:0], 8'h00);
         `CHK("reset value", 8'h00, v)
      end
   endtask
   initial begin
      repeat (20) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      check_cleared;
      for (t = 0; t < 8; t++) begin
         rnd = lfsr(rnd);
         o = rnd[7:0];
         d = rnd[15:8];
         bus(1, 8'h40, {t[2:0], 2'b10});
         bus(1, 8'h41, o);
         bus(1, 8'h42, d);
         bus(1, 8'h41, o);
         bus(0, 8'h42, 8'h00);
         if (t < 7) `CHK("ana value", d, v)
         for (i = 0; i < 6; i++)
            if (t == 6 ? i < 3 : i == t - 1)
               `CHK("ana block", d, irab_far_side_i.amem[i][o])
         bus(0, 8'h41, 8'h00);
         if (t > 0 && t < 7) `CHK("ana offset", o + 8'h01, v)
         pc = irab_far_side_i.prefetch_count;
         bus(1, 8'h40, {t[2:0], 2'b11});
         bus(1, 8'h41, o);
         bus(0, 8'h42, 8'h00);
         bus(0, 8'h40, 8'h00);
         `CHK("ana control", {t[2:0], 2'b11}, v)
         `CHK("prefetch", pc + 2 * (t > 0 && t < 7), irab_far_side_i.prefetch_count)
      end
      for (t = 0; t < 4; t++) begin
         rnd = lfsr(rnd);
         wd = rnd;
         wait_q <= rnd[3:0];
         bus(1, 8'h48, {t[1:0], 3'b101});
         bus(1, 8'h49, 8'h10);
         bus(1, 8'h4a, t[7:0]);
         for (i = 0; i < 4; i++)
            bus(1, 8'h4b + i, wd[8*i +: 8]);
         for (i = 0; i < 30 && apb_psel_o !== 1'b0; i++)
            @(posedge clk_sys_i) #1;
         bus(1, 8'h49, 8'h10);
         bus(1, 8'h48, {t[1:0], 3'b111});
         i = 0;
         do begin
            bus(0, 8'h48, 8'h00);
            i++;
         end while (v[1] !== 1'b0 && i < 40);
         `CHK("read start", 1'b0, v[1])
         if (t > 1)
            wd = {t[7:0], 8'h10, 16'hc3a5};
         for (i = 0; i < 4; i++) begin
            bus(0, 8'h4b + i, 8'h00);
            `CHK("apb data", wd[8*i +: 8], v)
         end
         bus(0, 8'h49, 8'h00);
         `CHK("apb addr low", t ? 8'h11 : 8'h14, v)
         bus(0, 8'h4a, 8'h00);
         `CHK("apb addr high", t[7:0], v)
      end
      bus(1, 8'h48, 8'h02);
      bus(0, 8'h48, 8'h00);
      `CHK("apb disabled", 1'b0, apb_psel_o)
      `CHK("start dropped", 1'b0, v[1])
      // A second reset after traffic must clear every register again.
      @(posedge clk_sys_i);
      rstn_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      check_cleared;
      summarize;
   end
endmodule // tb_irab_bridge
